// >>> dcc_pkg.sv
// Package with register map, field positions and carrier types for the DMA channel registers.
`default_nettype none
package dcc_pkg;
  // Register byte addresses; bit 8 selects the channel.
  localparam logic [11:0] OFS_CTRL0 = 12'h000;
  localparam logic [11:0] OFS_CTRL1 = 12'h004;
  localparam logic [11:0] OFS_HOLD = 12'h008;
  localparam logic [11:0] OFS_SBA_LO = 12'h00C;
  localparam logic [11:0] OFS_SBA_HI = 12'h010;
  localparam logic [11:0] OFS_SBA_UP = 12'h014;
  localparam logic [11:0] OFS_SLP_LO = 12'h018;
  localparam logic [11:0] OFS_SLP_HI = 12'h01C;
  localparam logic [11:0] OFS_SLP_UP = 12'h020;
  localparam logic [11:0] OFS_DLP_LO = 12'h024;
  localparam logic [11:0] OFS_DLP_HI = 12'h028;
  localparam logic [11:0] OFS_DBA_LO = 12'h02C;
  localparam logic [11:0] OFS_DBA_HI = 12'h030;
  localparam logic [11:0] OFS_STATUS = 12'h034;
  localparam int CH_SEL_BIT = 8;
  localparam int NUM_CH = 2;
  // Control register 0 fields.
  localparam int C0_ENABLE = 7;
  localparam int C0_START_ARM = 6;
  localparam int C0_ACTIVE = 5;
  localparam int C0_ABORT_ARM = 2;
  localparam int C0_PENDING = 0;
  localparam logic [7:0] C0_WMASK = 8'hE4;
  // Control register 1 fields.
  localparam int C1_DSTEP_LSB = 6;
  localparam int C1_DST_HALT = 5;
  localparam int C1_REGION_LSB = 3;
  localparam int C1_SSTEP_LSB = 1;
  localparam int C1_SRC_HALT = 0;
  localparam logic [7:0] SBA_UP_MASK = 8'h3F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Status register bits (sticky, write one to clear).
  localparam int ST_DST_CNT = 0;
  localparam int ST_OVERRUN = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    STEP_HOLD = 2'b00,
    STEP_INC = 2'b01,
    STEP_DEC = 2'b10,
    STEP_RSVD = 2'b11
  } dcc_step_e;
  typedef enum logic [1:0] {
    REG_DATA = 2'b00,
    REG_FLASH = 2'b01,
    REG_EEPROM = 2'b10
  } dcc_region_e;
  // One channel's hardware event inputs.
  typedef struct packed {
    logic start_trig;
    logic abort_trig;
    logic src_read_done;
    logic dst_write_done;
    logic src_reload;
    logic dst_reload;
    logic [7:0] read_data;
  } dcc_evt_s;
  // One channel's view outward to the transfer engine.
  typedef struct packed {
    logic run;
    dcc_region_e region;
    logic [21:0] src_addr;
    logic [15:0] dst_addr;
    logic [7:0] hold;
  } dcc_xfer_s;
endpackage
`default_nettype wire

// >>> dcc_top.sv
// Two-channel DMA control and source register set with an AXI4-Lite slave.
//
// How it works
// - Control 0 bit 7 enables the channel; zero disables it.
// - Bit 6 arms hardware start triggers; hardware may clear it.
// - Bit 5 shows a transaction; software writes, hardware sets and clears.
// - Bit 2 arms abort triggers; hardware may clear it.
// - Read-only bit 0 is high while the holding byte awaits delivery.
// - Source step 10 decrements, 01 increments, 00 holds the 22-bit pointer.
// - Region field selects EEPROM on 1x, flash on 01, data space on 00.
// - Destination halt bit clears start arming on destination counter reload.
// - Source halt bit clears start arming on source counter reload.
// - Holding byte is readable, read only.
// - Source begin address is 22 bits over three bytes, upper six bits.
// - Live source pointer is readable as bytes, distinct from begin address.
// - Every reset zeroes all implemented fields.
// - Unimplemented bits read as zero.
// - Two identical channels each with a full register copy.
// - A halting destination reload also raises the destination count flag.
// - A start trigger during a message raises the overrun flag.
// - Abort finishes the access, clears active and arms; resume later.
// - Clearing enable returns the channel registers to reset values.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dcc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transfer engine events and controls, one per channel
  input wire dcc_pkg::dcc_evt_s [1:0] evt,
  output dcc_pkg::dcc_xfer_s [1:0] xfer
);
  import dcc_pkg::*;

  // Step a pointer by the selected mode; reserved code holds it.
  function automatic logic [21:0] step_ptr(input logic [21:0] p, input logic [1:0] m);
    case (m)
      STEP_INC: step_ptr = p + 22'h000001;
      STEP_DEC: step_ptr = p - 22'h000001;
      default: step_ptr = p;
    endcase
  endfunction

  // Bus handshake state.
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wlane_r, wlane_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_write;
  logic [NUM_CH-1:0] wr_ch;
  logic [11:0] wr_off;
  logic [7:0] wr_byte;
  logic wr_ok;

  // Per-channel register state.
  logic [7:0] ctrl0_r [NUM_CH], ctrl0_nxt [NUM_CH];
  logic [7:0] ctrl1_r [NUM_CH], ctrl1_nxt [NUM_CH];
  logic [7:0] hold_r [NUM_CH], hold_nxt [NUM_CH];
  logic [21:0] sba_r [NUM_CH], sba_nxt [NUM_CH];
  logic [21:0] slp_r [NUM_CH], slp_nxt [NUM_CH];
  logic [15:0] dba_r [NUM_CH], dba_nxt [NUM_CH];
  logic [15:0] dlp_r [NUM_CH], dlp_nxt [NUM_CH];
  logic [1:0] stat_r [NUM_CH], stat_nxt [NUM_CH];
  logic abort_pend_r [NUM_CH], abort_pend_nxt [NUM_CH];
  dcc_xfer_s [1:0] xfer_r;

  function automatic logic known_off(input logic [11:0] a);
    logic [11:0] o;
    o = {a[11:CH_SEL_BIT+1], 1'b0, a[CH_SEL_BIT-1:0]};
    known_off = (a[11:CH_SEL_BIT+1] == '0) && (o <= OFS_STATUS) && (a[1:0] == 2'b00);
  endfunction

  // Write channel: address and data taken in either order.
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wlane_nxt = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wr_ok = known_off(awaddr_r);
  assign wr_off = {awaddr_r[11:CH_SEL_BIT+1], 1'b0, awaddr_r[CH_SEL_BIT-1:0]};
  assign wr_byte = wdata_r[7:0];
  assign wr_ch[0] = do_write && wr_ok && wlane_r && !awaddr_r[CH_SEL_BIT];
  assign wr_ch[1] = do_write && wr_ok && wlane_r && awaddr_r[CH_SEL_BIT];

  // Channel logic, repeated per channel.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_comb begin
      logic en, busy, halt;
      logic [1:0] hw_set;
      en = ctrl0_r[c][C0_ENABLE];
      busy = ctrl0_r[c][C0_ACTIVE];
      halt = 1'b0;
      hw_set = 2'b00;
      ctrl0_nxt[c] = ctrl0_r[c];
      ctrl1_nxt[c] = ctrl1_r[c];
      hold_nxt[c] = hold_r[c];
      sba_nxt[c] = sba_r[c];
      slp_nxt[c] = slp_r[c];
      dba_nxt[c] = dba_r[c];
      dlp_nxt[c] = dlp_r[c];
      abort_pend_nxt[c] = abort_pend_r[c];
      if (en) begin
        // Hardware start sets the active bit; a start during a message is an overrun.
        if (evt[c].start_trig && ctrl0_r[c][C0_START_ARM]) begin
          if (busy) hw_set[ST_OVERRUN] = 1'b1;
          ctrl0_nxt[c][C0_ACTIVE] = 1'b1;
        end
        if (evt[c].abort_trig && ctrl0_r[c][C0_ABORT_ARM]) begin
          abort_pend_nxt[c] = 1'b1;
          ctrl0_nxt[c][C0_START_ARM] = 1'b0;
          ctrl0_nxt[c][C0_ABORT_ARM] = 1'b0;
        end
        // Abort waits until no byte is in flight so the access finishes first.
        if (abort_pend_r[c] && !ctrl0_r[c][C0_PENDING]) begin
          ctrl0_nxt[c][C0_ACTIVE] = 1'b0;
          abort_pend_nxt[c] = 1'b0;
        end
        if (evt[c].src_read_done) begin
          hold_nxt[c] = evt[c].read_data;
          ctrl0_nxt[c][C0_PENDING] = 1'b1;
          slp_nxt[c] = step_ptr(slp_r[c], ctrl1_r[c][C1_SSTEP_LSB +: 2]);
        end
        if (evt[c].dst_write_done) begin
          ctrl0_nxt[c][C0_PENDING] = 1'b0;
          dlp_nxt[c] = 16'(step_ptr({6'h00, dlp_r[c]}, ctrl1_r[c][C1_DSTEP_LSB +: 2]));
        end
        if (evt[c].src_reload) begin
          slp_nxt[c] = sba_r[c];
          if (ctrl1_r[c][C1_SRC_HALT]) halt = 1'b1;
        end
        if (evt[c].dst_reload) begin
          dlp_nxt[c] = dba_r[c];
          if (ctrl1_r[c][C1_DST_HALT]) begin
            halt = 1'b1;
            hw_set[ST_DST_CNT] = 1'b1;
          end
        end
        if (halt) ctrl0_nxt[c][C0_START_ARM] = 1'b0;
      end
      stat_nxt[c] = stat_r[c] | hw_set;
      // Software writes; the hardware set of a status flag wins over its clear.
      if (wr_ch[c]) begin
        case (wr_off)
          OFS_CTRL0: begin
            ctrl0_nxt[c] = (wr_byte & C0_WMASK) | (ctrl0_nxt[c] & ~C0_WMASK);
            if (wr_byte[C0_ACTIVE]) abort_pend_nxt[c] = 1'b0;
          end
          OFS_CTRL1: ctrl1_nxt[c] = wr_byte;
          OFS_SBA_LO: sba_nxt[c][7:0] = wr_byte;
          OFS_SBA_HI: sba_nxt[c][15:8] = wr_byte;
          OFS_SBA_UP: sba_nxt[c][21:16] = wr_byte[5:0];
          OFS_DBA_LO: dba_nxt[c][7:0] = wr_byte;
          OFS_DBA_HI: dba_nxt[c][15:8] = wr_byte;
          OFS_STATUS: stat_nxt[c] = (stat_r[c] & ~wr_byte[1:0]) | hw_set;
          default: ;
        endcase
      end
      // Only the clearing of the enable resets the channel, so set-up writes made
      // before enabling are kept.
      if (en && !ctrl0_nxt[c][C0_ENABLE]) begin
        ctrl0_nxt[c] = RST_BYTE;
        ctrl1_nxt[c] = RST_BYTE;
        hold_nxt[c] = RST_BYTE;
        sba_nxt[c] = '0;
        slp_nxt[c] = '0;
        dba_nxt[c] = '0;
        dlp_nxt[c] = '0;
        stat_nxt[c] = '0;
        abort_pend_nxt[c] = 1'b0;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl0_r[c] <= RST_BYTE;
        ctrl1_r[c] <= RST_BYTE;
        hold_r[c] <= RST_BYTE;
        sba_r[c] <= '0;
        slp_r[c] <= '0;
        dba_r[c] <= '0;
        dlp_r[c] <= '0;
        stat_r[c] <= '0;
        abort_pend_r[c] <= 1'b0;
        xfer_r[c] <= '0;
      end else begin
        ctrl0_r[c] <= ctrl0_nxt[c];
        ctrl1_r[c] <= ctrl1_nxt[c];
        hold_r[c] <= hold_nxt[c];
        sba_r[c] <= sba_nxt[c];
        slp_r[c] <= slp_nxt[c];
        dba_r[c] <= dba_nxt[c];
        dlp_r[c] <= dlp_nxt[c];
        stat_r[c] <= stat_nxt[c];
        abort_pend_r[c] <= abort_pend_nxt[c];
        xfer_r[c].run <= ctrl0_nxt[c][C0_ENABLE] && ctrl0_nxt[c][C0_ACTIVE]
                         && !abort_pend_nxt[c];
        xfer_r[c].region <= ctrl1_nxt[c][C1_REGION_LSB + 1] ? REG_EEPROM :
                            dcc_region_e'(ctrl1_nxt[c][C1_REGION_LSB +: 2]);
        xfer_r[c].src_addr <= slp_nxt[c];
        xfer_r[c].dst_addr <= dlp_nxt[c];
        xfer_r[c].hold <= hold_nxt[c];
      end
    end
  end

  // Read channel: one word per request, answered the cycle after it is taken.
  always_comb begin
    logic [7:0] b;
    logic ch;
    logic [11:0] off;
    b = 8'h00;
    ch = s_axi_araddr[CH_SEL_BIT];
    off = {s_axi_araddr[11:CH_SEL_BIT+1], 1'b0, s_axi_araddr[CH_SEL_BIT-1:0]};
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      case (off)
        OFS_CTRL0: b = ctrl0_r[ch];
        OFS_CTRL1: b = ctrl1_r[ch];
        OFS_HOLD: b = hold_r[ch];
        OFS_SBA_LO: b = sba_r[ch][7:0];
        OFS_SBA_HI: b = sba_r[ch][15:8];
        OFS_SBA_UP: b = {2'b00, sba_r[ch][21:16]};
        OFS_SLP_LO: b = slp_r[ch][7:0];
        OFS_SLP_HI: b = slp_r[ch][15:8];
        OFS_SLP_UP: b = {2'b00, slp_r[ch][21:16]};
        OFS_DLP_LO: b = dlp_r[ch][7:0];
        OFS_DLP_HI: b = dlp_r[ch][15:8];
        OFS_DBA_LO: b = dba_r[ch][7:0];
        OFS_DBA_HI: b = dba_r[ch][15:8];
        OFS_STATUS: b = {6'h00, stat_r[ch]};
        default: b = 8'h00;
      endcase
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, b};
      rresp_nxt = known_off(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      // Ready is registered, so it is offered only while nothing is held.
      s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
      s_axi_wready <= !w_held_nxt && !bvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign xfer = xfer_r;
endmodule
`default_nettype wire

// >>> dcc_top_properties.sv
// Checker with the bus and transfer port properties of the DMA register block.
`timescale 1ns/1ps
`default_nettype none
module dcc_top_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Engine side
  input wire dcc_pkg::dcc_evt_s [1:0] evt,
  input wire dcc_pkg::dcc_xfer_s [1:0] xfer
);
  import dcc_pkg::*;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_narrow;
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
  endsequence
  property p_r_answer;
    s_ar_taken |=> s_r_narrow;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late or wide");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data dropped early");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
  property p_one_read;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_one_read: assert property (p_one_read) else $error("second read accepted");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
  // Explicit disable so that the reset itself is watched.
  property p_rst;
    disable iff (1'b0) !aresetn |=> !s_axi_rvalid && !s_axi_bvalid && xfer == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_region;
    xfer[0].region != 2'b11 && xfer[1].region != 2'b11;
  endproperty
  a_region: assert property (p_region) else $error("reserved region code driven");
  property p_hold_load;
    xfer[0].run && evt[0].src_read_done |=> xfer[0].hold == $past(evt[0].read_data);
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("holding byte not loaded");
endmodule
bind dcc_top dcc_top_properties dcc_top_properties_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .evt(evt), .xfer(xfer));
`default_nettype wire

// >>> dcc_engine_model.sv
// Stand-in transfer engine that pulses one channel's events on request.
`timescale 1ns/1ps
`default_nettype none
module dcc_engine_model (
  // Clock
  input wire logic aclk,
  // Requests: read, start, abort, write done, source reload, destination reload
  input wire logic [5:0] kick,
  input wire logic [7:0] byte_in,
  // Channel
  input wire dcc_pkg::dcc_xfer_s chan,
  output dcc_pkg::dcc_evt_s evt_out
);
  import dcc_pkg::*;
  logic rd_r = 1'b0;
  logic [7:0] byte_r = 8'h00;
  // A read only happens while the channel runs, as the real engine would.
  always_ff @(posedge aclk) begin
    rd_r <= kick[5] && chan.run;
    byte_r <= kick[5] ? byte_in : byte_r;
  end
  // Outside a read strobe the data lines carry the inverse, so stale bytes never match.
  assign evt_out = {kick[4], kick[3], rd_r, kick[2], kick[1:0], rd_r ? byte_r : ~byte_r};
endmodule
`default_nettype wire

// >>> test_dcc_top.sv
// Self-checking bench for the two-channel DMA control register block.
`timescale 1ns/1ps
`default_nettype none
module test_dcc_top;
  import dcc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] kick = '0;
  logic [7:0] byte_v = '0;
  wire dcc_evt_s [1:0] evt;
  dcc_xfer_s [1:0] xfer;
  int n_errors = 0;
  int n_tests = 0;
  always #4 aclk = ~aclk;
  dcc_top dcc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt), .xfer(xfer));
  for (genvar c = 0; c < NUM_CH; c++) begin : g_eng
    dcc_engine_model dcc_engine_model_inst (.aclk(aclk), .kick(c == 0 ? kick : 6'h00),
      .byte_in(byte_v), .chan(xfer[c]), .evt_out(evt[c]));
  end
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    n_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) bad($sformatf("%s got %h want %h", m, g, e));
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    if (n >= 40) begin
      bad("write hang");
      close_out();
    end
    chk(bresp, RESP_OKAY, "bresp");
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 40) begin
      bad("read hang");
      close_out();
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(r, RESP_OKAY, "rresp");
    chk(d, e, $sformatf("read %h", a));
  endtask
  // Pulse engine events, then let the registered outputs settle.
  task automatic ev(input logic [5:0] k);
    @(posedge aclk);
    kick <= k;
    @(posedge aclk);
    kick <= 6'h00;
    @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic t_reset();
    for (int c = 0; c < NUM_CH; c++) begin
      for (int i = 0; i < 14; i++) begin
        rchk(12'(c * 256 + i * 4), 32'h0);
      end
    end
  endtask
  task automatic t_access();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_CTRL1, 8'hFF);
    rchk(OFS_CTRL1, 32'hFF);
    rchk(OFS_CTRL1 | 12'h100, 32'h0);
    wr(OFS_SBA_UP, 8'hFF);
    rchk(OFS_SBA_UP, 32'h3F);
    wr(OFS_CTRL0, 8'hFF);
    rchk(OFS_CTRL0, 32'hE4);
    wr(OFS_HOLD, 8'h77);
    rchk(OFS_HOLD, 32'h0);
    rd(12'h0FC, d, r);
    chk(r, RESP_SLVERR, "unmapped");
    wr(OFS_CTRL0, 8'h00);
    rchk(OFS_CTRL1, 32'h0);
    rchk(OFS_SBA_UP, 32'h0);
  endtask
  // Every step and region code, with the halt bits taken from the code.
  task automatic t_steps();
    logic [1:0] s;
    logic [21:0] sp;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      sp = 22'h021000 + (s == 2'b01 ? 22'h1 : 22'h0) - (s == 2'b10 ? 22'h1 : 22'h0);
      byte_v <= 8'hA0 + 8'(i);
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_SBA_HI, 8'h10);
      wr(OFS_SBA_UP, 8'h02);
      wr(OFS_CTRL1, {s, s[1], s, s, s[0]});
      // Bus access for the channel is taken as granted before it is enabled.
      wr(OFS_CTRL0, 8'h80);
      ev(6'h02);
      wr(OFS_CTRL0, 8'hC0);
      chk(xfer[0].src_addr, 22'h021000, "reload");
      ev(6'h10);
      ev(6'h20);
      rchk(OFS_CTRL0, 32'hE1);
      chk(xfer[0].hold, 8'hA0 + 8'(i), "hold");
      ev(6'h04);
      rchk(OFS_CTRL0, 32'hE0);
      chk(xfer[0].src_addr, sp, "src step");
      chk(xfer[0].dst_addr, 16'(sp[15:0] - 16'h1000), "dst step");
      chk(xfer[0].region, s[1] ? 2'b10 : s, "region");
      rchk(OFS_SLP_HI, 32'(sp[15:8]));
      ev(6'h02);
      rchk(OFS_CTRL0, s[0] ? 32'hA0 : 32'hE0);
      ev(6'h01);
      rchk(OFS_CTRL0, s == 2'b00 ? 32'hE0 : 32'hA0);
      rchk(OFS_STATUS, 32'(s[1]));
    end
  endtask
  task automatic t_abort();
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL0, 8'hC4);
    ev(6'h10);
    ev(6'h10);
    rchk(OFS_STATUS, 32'h2);
    wr(OFS_STATUS, 8'h02);
    rchk(OFS_STATUS, 32'h0);
    ev(6'h20);
    ev(6'h08);
    rchk(OFS_CTRL0, 32'hA1);
    chk(xfer[0].run, 1'b0, "run after abort");
    ev(6'h04);
    rchk(OFS_CTRL0, 32'h80);
    ev(6'h10);
    rchk(OFS_CTRL0, 32'h80);
    wr(OFS_CTRL0, 8'hA0);
    chk(xfer[0].run, 1'b1, "run after resume");
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_access();
    t_steps();
    t_abort();
    close_out();
  end
endmodule
`default_nettype wire
